// ### src/comparator_fault_alert_status.sv
// Purpose: comparator alert and balance-switch fault status registers with software reset request
// Assumes: comparison results and strobes come from logic on clk
// Notes:   register access is one cycle, read data returns one cycle later
//          no software clear: flags move on acquisition strobes, and comparator flags also clear when their enable bit drops
`include "comparator_fault_alert_consts.svh"

module comparator_fault_alert_status (
  input  wire logic                                    clk,
  input  wire logic                                    sys_rst,
  input  wire comparator_fault_alert_pkg::reg_addr_type reg_addr,
  input  wire logic                                    reg_write,
  input  wire logic                                    reg_read,
  input  wire comparator_fault_alert_pkg::reg_word_type reg_wdata,
  output logic [`REG_DATA_WIDTH-1:0]                   reg_rdata_q,
  output logic                                         reg_rvalid_q,
  output logic                                         reg_error_q,
  input  wire comparator_fault_alert_pkg::aux_vector_type aux_overvoltage_alert_enable,
  input  wire comparator_fault_alert_pkg::aux_vector_type aux_undervoltage_alert_enable,
  input  wire logic                                    comparator_acquire_done,
  input  wire comparator_fault_alert_pkg::aux_vector_type aux_above_upper_threshold,
  input  wire comparator_fault_alert_pkg::aux_vector_type aux_below_lower_threshold,
  input  wire logic                                    balance_diag_done,
  input  wire comparator_fault_alert_pkg::balance_vector_type balance_diag_over_threshold,
  output logic [`BALANCE_SWITCHES-1:0]                 balance_switch_fault_flags_q,
  output logic                                         software_power_on_reset_request_q
);
  import comparator_fault_alert_pkg::*;

  // ****************************************
  // address decode
  // ****************************************
  function automatic reg_select_type decode_select(input reg_addr_type addr);
    reg_select_type sel;
    sel = sel_none;
    case (addr)
      `OFS_AUX_COLD_COMPARATOR_ALERTS: begin
        sel = sel_aux_cold;
      end
      `OFS_AUX_HOT_COMPARATOR_ALERTS: begin
        sel = sel_aux_hot;
      end
      `OFS_BALANCE_SWITCH_FAULT_SUMMARY: begin
        sel = sel_balance;
      end
      `OFS_SOFTWARE_ACTION_REQUEST: begin
        sel = sel_action;
      end
      default: begin
        sel = sel_none;
      end
    endcase
    return sel;
  endfunction

  // ****************************************
  // flag groups
  // ****************************************
  alert_flag_if #(.WIDTH(`AUX_CHANNELS))     cold_port ();
  alert_flag_if #(.WIDTH(`AUX_CHANNELS))     hot_port ();
  alert_flag_if #(.WIDTH(`BALANCE_SWITCHES)) balance_port ();

  // both comparator groups share one acquisition strobe
  // cold comparator path
  assign cold_port.acquire   = comparator_acquire_done;
  assign cold_port.condition = aux_above_upper_threshold;
  assign cold_port.enable    = aux_overvoltage_alert_enable;

  assign hot_port.acquire    = comparator_acquire_done;
  assign hot_port.condition  = aux_below_lower_threshold;
  assign hot_port.enable     = aux_undervoltage_alert_enable;

  // balance flags have no enable and are always evaluated
  // balance diagnostic path
  assign balance_port.acquire   = balance_diag_done;
  assign balance_port.condition = balance_diag_over_threshold;
  assign balance_port.enable    = {`BALANCE_SWITCHES{1'b1}};

  alert_flag_group #(.WIDTH(`AUX_CHANNELS)) cold_group (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flag_port (cold_port)
  );

  alert_flag_group #(.WIDTH(`AUX_CHANNELS)) hot_group (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flag_port (hot_port)
  );

  alert_flag_group #(.WIDTH(`BALANCE_SWITCHES)) balance_group (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flag_port (balance_port)
  );

  // ****************************************
  // register read path
  // ****************************************
  reg_word_type                 rdata_d;
  logic                         rvalid_d;
  logic                         error_d;
  reg_select_type               access_sel;
  reg_word_type                 cold_word;
  reg_word_type                 hot_word;
  reg_word_type                 balance_word;

  // status words keep their unused upper bits at zero
  function automatic reg_word_type pad_aux(input aux_vector_type flags);
    reg_word_type word;
    word                    = `RST_REG_WORD;
    word[`AUX_CHANNELS-1:0] = flags;
    return word;
  endfunction

  assign access_sel   = decode_select(reg_addr);
  assign cold_word    = pad_aux(cold_port.flags);
  assign hot_word     = pad_aux(hot_port.flags);
  assign balance_word = {{(`REG_DATA_WIDTH-`BALANCE_SWITCHES){1'b0}}, balance_port.flags};

  always_comb begin
    rdata_d  = `RST_REG_WORD;
    rvalid_d = reg_read;
    // unmapped access answers zero with error
    error_d  = (reg_read || reg_write) && (access_sel == sel_none);
    if (reg_read) begin
      case (access_sel)
        sel_aux_cold: begin
          rdata_d = cold_word;
        end
        sel_aux_hot: begin
          rdata_d = hot_word;
        end
        sel_balance: begin
          rdata_d = balance_word;
        end
        sel_action: begin
          rdata_d = `RST_REG_WORD;
        end
        default: begin
          rdata_d = `RST_REG_WORD;
        end
      endcase
    end
  end

  // read data falls back to zero after its answer cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata_q  <= `RST_REG_WORD;
      reg_rvalid_q <= 1'b0;
      reg_error_q  <= 1'b0;
    end else begin
      reg_rdata_q  <= rdata_d;
      reg_rvalid_q <= rvalid_d;
      reg_error_q  <= error_d;
    end
  end

  // ****************************************
  // balance summary output
  // ****************************************
  balance_vector_type balance_out_d;

  // mirror kept in a flop so the output is registered; lags the flags by one cycle
  always_comb begin
    balance_out_d = balance_port.flags;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      balance_switch_fault_flags_q <= `RST_BALANCE_FLAGS;
    end else begin
      balance_switch_fault_flags_q <= balance_out_d;
    end
  end

  // ****************************************
  // register write path
  // ****************************************
  logic write_action;
  logic por_request_d;

  // a write of zero, or to a status word, leaves all state alone
  assign write_action = reg_write && (access_sel == sel_action);

  always_comb begin
    // writes to status words are dropped
    por_request_d = 1'b0;
    if (write_action && reg_wdata[`SW_POR_BIT]) begin
      por_request_d = 1'b1;
    end
  end

  // pulse only; the reset itself is carried out outside this bank
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      software_power_on_reset_request_q <= 1'b0;
    end else begin
      software_power_on_reset_request_q <= por_request_d;
    end
  end

endmodule

// ### common/comparator_fault_alert_consts.svh
// Purpose: register offsets, field layouts and reset values of the alert status bank
// Assumes: 8-bit register index, 16-bit register word
// Notes:   included by the package and the status bank design file
`ifndef COMPARATOR_FAULT_ALERT_CONSTS_SVH
`define COMPARATOR_FAULT_ALERT_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_AUX_COLD_COMPARATOR_ALERTS   8'h10
`define OFS_AUX_HOT_COMPARATOR_ALERTS    8'h11
`define OFS_BALANCE_SWITCH_FAULT_SUMMARY 8'h12
`define OFS_SOFTWARE_ACTION_REQUEST      8'h13

// ****************************************
// widths and field positions
// ****************************************
`define REG_ADDR_WIDTH                   8
`define REG_DATA_WIDTH                   16
`define AUX_CHANNELS                     6
`define BALANCE_SWITCHES                 14
`define SW_POR_BIT                       0

// ****************************************
// reset values
// ****************************************
`define RST_AUX_FLAGS                    6'h00
`define RST_BALANCE_FLAGS                14'h0000
`define RST_REG_WORD                     16'h0000

`endif

// ### common/comparator_fault_alert_pkg.sv
// Purpose: shared types of the alert status bank
// Assumes: constants come from the consts header
// Notes:   register select enumeration is used by the address decoder
`include "comparator_fault_alert_consts.svh"

package comparator_fault_alert_pkg;

  typedef logic [`REG_ADDR_WIDTH-1:0]   reg_addr_type;
  typedef logic [`REG_DATA_WIDTH-1:0]   reg_word_type;
  typedef logic [`AUX_CHANNELS-1:0]     aux_vector_type;
  typedef logic [`BALANCE_SWITCHES-1:0] balance_vector_type;

  typedef enum logic [2:0] {
    sel_none,
    sel_aux_cold,
    sel_aux_hot,
    sel_balance,
    sel_action
  } reg_select_type;

endpackage

// ### common/alert_flag_if.sv
// Purpose: carrier between the register bank and one flag group
// Assumes: single clock, flags updated on acquisition strobes
// Notes:   width set per group
interface alert_flag_if #(
  parameter int WIDTH = 6
);
  logic             acquire;
  logic [WIDTH-1:0] condition;
  logic [WIDTH-1:0] enable;
  logic [WIDTH-1:0] flags;

  modport bank (
    output acquire,
    output condition,
    output enable,
    input  flags
  );

  modport group (
    input  acquire,
    input  condition,
    input  enable,
    output flags
  );
endinterface

// ### src/alert_flag_group.sv
// Purpose: one group of self-clearing alert flags
// Assumes: acquire is a one-cycle strobe at the end of an acquisition
// Notes:   flags follow the latest enabled result, no software clear
module alert_flag_group #(
  parameter int WIDTH = 6
) (
  input  wire logic  clk,
  input  wire logic  sys_rst,
  alert_flag_if.group flag_port
);

  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;

  // ****************************************
  // next flag values
  // ****************************************
  always_comb begin
    flags_d = flags_q;
    if (flag_port.acquire) begin
      flags_d = flag_port.condition;
    end
    flags_d = flags_d & flag_port.enable;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flag_port.flags = flags_q;

endmodule

// ### tb/comparator_fault_alert_chk.sv
// Purpose: concurrent checks on the alert status bank ports
// Assumes: one clock, synchronous active-high reset
// Notes:   attached by the bind at the foot of this file
module comparator_fault_alert_chk
  import comparator_fault_alert_pkg::*;
(
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire reg_addr_type       reg_addr,
  input wire logic               reg_write,
  input wire logic               reg_read,
  input wire reg_word_type       reg_wdata,
  input wire logic [15:0]        reg_rdata_q,
  input wire logic               reg_rvalid_q,
  input wire logic               reg_error_q,
  input wire aux_vector_type     aux_overvoltage_alert_enable,
  input wire aux_vector_type     aux_undervoltage_alert_enable,
  input wire logic               comparator_acquire_done,
  input wire aux_vector_type     aux_above_upper_threshold,
  input wire aux_vector_type     aux_below_lower_threshold,
  input wire logic               balance_diag_done,
  input wire balance_vector_type balance_diag_over_threshold,
  input wire logic [13:0]        balance_switch_fault_flags_q,
  input wire logic               software_power_on_reset_request_q
);
  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic bad_access;
  logic por_write;
  assign bad_access = (reg_read || reg_write) && (reg_addr < 8'h10 || reg_addr > 8'h13);
  assign por_write  = reg_write && reg_addr == 8'h13 && reg_wdata[0];

  chk_read_answer: assert property (reg_read |=> reg_rvalid_q && reg_error_q == $past(bad_access))
    else $error("read not answered one cycle later");
  chk_idle_rdata: assert property (!reg_rvalid_q |-> reg_rdata_q == 16'h0000)
    else $error("read data not zero outside an answer");
  chk_unmapped_error: assert property (bad_access |=> reg_error_q && reg_rdata_q == 16'h0000)
    else $error("unmapped access without error");
  chk_por_pulse: assert property (por_write |=> software_power_on_reset_request_q)
    else $error("reset request not raised after write");
  chk_por_cause: assert property (software_power_on_reset_request_q |-> $past(por_write))
    else $error("reset request without a write of one");
  chk_cold_flags: assert property (comparator_acquire_done ##1 (reg_read && reg_addr == 8'h10
    && !comparator_acquire_done && $stable(aux_overvoltage_alert_enable)) |=> reg_rdata_q ==
    {10'h000, $past(aux_above_upper_threshold, 2) & $past(aux_overvoltage_alert_enable, 2)})
    else $error("cold flags differ from gated comparison");
  chk_hot_flags: assert property (comparator_acquire_done ##1 (reg_read && reg_addr == 8'h11
    && !comparator_acquire_done && $stable(aux_undervoltage_alert_enable)) |=> reg_rdata_q ==
    {10'h000, $past(aux_below_lower_threshold, 2) & $past(aux_undervoltage_alert_enable, 2)})
    else $error("hot flags differ from gated comparison");
  chk_balance_copy: assert property (balance_diag_done |-> ##2
    balance_switch_fault_flags_q == $past(balance_diag_over_threshold, 2))
    else $error("balance flags do not follow diagnostic");
  chk_balance_hold: assert property (!balance_diag_done |-> ##2 $stable(balance_switch_fault_flags_q))
    else $error("balance flags moved without diagnostic");

  cover property (comparator_acquire_done ##1 reg_read);
  cover property (software_power_on_reset_request_q);
  cover property (reg_error_q);
endmodule

bind comparator_fault_alert_status comparator_fault_alert_chk chk_i (.*);

// ### tb/testbench.sv
// Purpose: self-checking bench for the alert status bank
// Assumes: answers one cycle after each strobe
// Notes:   seeded random flag patterns plus corner cases
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import comparator_fault_alert_pkg::*;
  logic               clk, sys_rst, reg_write, reg_read, comparator_acquire_done, balance_diag_done;
  logic               reg_rvalid_q, reg_error_q, software_power_on_reset_request_q;
  reg_addr_type       reg_addr;
  reg_word_type       reg_wdata;
  logic [15:0]        reg_rdata_q;
  aux_vector_type     aux_overvoltage_alert_enable, aux_undervoltage_alert_enable, up, dn;
  aux_vector_type     aux_above_upper_threshold, aux_below_lower_threshold;
  balance_vector_type balance_diag_over_threshold, bv;
  logic [13:0]        balance_switch_fault_flags_q;
  int                 mismatches, checks_done;

  comparator_fault_alert_status uut (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [15:0] gated(aux_vector_type cond, aux_vector_type en);
    return {10'h000, cond & en};
  endfunction
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(reg_addr_type a, logic [15:0] exp, string name);
    reg_addr = a;
    reg_read = 1'b1;
    tick();
    reg_read = 1'b0;
    check(name, {reg_rvalid_q, reg_error_q, reg_rdata_q[13:0]}, {1'b1, a < 8'h10 || a > 8'h13, exp[13:0]});
    check(name, {2'b00, reg_rdata_q[15:14]}, {2'b00, exp[15:14]});
    // idle edge so the next strobe is never raised in the step that lowers this one
    tick();
  endtask
  task automatic wr(reg_addr_type a, reg_word_type d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    tick();
    reg_write = 1'b0;
    tick();
  endtask
  task automatic acquire(aux_vector_type u, aux_vector_type d);
    {aux_above_upper_threshold, aux_below_lower_threshold, comparator_acquire_done} = {u, d, 1'b1};
    tick();
    // stale conditions must not leak in without a strobe
    {aux_above_upper_threshold, aux_below_lower_threshold, comparator_acquire_done} = {~u, ~d, 1'b0};
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    void'($urandom(71));
    {reg_addr, reg_wdata, reg_write, reg_read, comparator_acquire_done, balance_diag_done} = '0;
    {aux_above_upper_threshold, aux_below_lower_threshold, balance_diag_over_threshold} = '0;
    {aux_overvoltage_alert_enable, aux_undervoltage_alert_enable} = '0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    for (int a = 8'h0F; a <= 8'h14; a++)
      rd(8'(a), 16'h0000, "reset");
    for (int i = 0; i < 24; i++) begin
      aux_overvoltage_alert_enable = (i < 2) ? 6'h3F : 6'($urandom);
      aux_undervoltage_alert_enable = (i < 2) ? 6'h3F : 6'($urandom);
      up = (i < 2) ? {6{i == 0}} : 6'($urandom);
      dn = (i < 2) ? {6{i == 0}} : 6'($urandom);
      acquire(up, dn);
      rd(8'h10, gated(up, aux_overvoltage_alert_enable), "cold");
      rd(8'h11, gated(dn, aux_undervoltage_alert_enable), "hot");
      wr(8'h10, 16'hFFFF);
      wr(8'h11, 16'hFFFF);
      rd(8'h10, gated(up, aux_overvoltage_alert_enable), "cold hold");
      rd(8'h11, gated(dn, aux_undervoltage_alert_enable), "hot hold");
    end
    // hot register read right after an acquisition
    acquire(6'h2A, 6'h15);
    rd(8'h11, gated(6'h15, aux_undervoltage_alert_enable), "hot first");
    for (int i = 0; i < 8; i++) begin
      bv = (i == 0) ? 14'h3FFF : 14'($urandom);
      {balance_diag_over_threshold, balance_diag_done} = {bv, 1'b1};
      tick();
      {balance_diag_over_threshold, balance_diag_done} = {~bv, 1'b0};
      wr(8'h12, 16'h0000);
      rd(8'h12, {2'b00, bv}, "balance");
      check("balance out", {2'b00, balance_switch_fault_flags_q}, {2'b00, bv});
    end
    wr(8'h20, 16'hFFFF);
    wr(8'h13, 16'hFFFE);
    check("por idle", {15'h0000, software_power_on_reset_request_q}, 16'h0000);
    // the pulse stands one cycle, so it is looked at right after the write edge
    {reg_addr, reg_wdata, reg_write} = {8'h13, 16'h0001, 1'b1};
    tick();
    reg_write = 1'b0;
    check("por pulse", {15'h0000, software_power_on_reset_request_q}, 16'h0001);
    rd(8'h13, 16'h0000, "action");
    check("por end", {15'h0000, software_power_on_reset_request_q}, 16'h0000);
    {aux_overvoltage_alert_enable, aux_undervoltage_alert_enable} = {6'h3F, 6'h3F};
    acquire(6'h3F, 6'h3F);
    sys_rst = 1'b1;
    tick();
    sys_rst = 1'b0;
    rd(8'h10, 16'h0000, "cold after reset");
    report_and_stop();
  end
endmodule
